// ===== common/irlink_pkg.sv
// Constants and types shared by the host serial port of the infrared link.
// Assumes a single 200 MHz system clock; every timing count derives from it.
package irlink_pkg;

    // -------------------------------------------------------------------
    // Clocks and bit timing
    // -------------------------------------------------------------------
    localparam int SYS_CLK_HZ = 200_000_000;
    localparam int SYS_CLK_PERIOD_NS = 1_000_000_000 / SYS_CLK_HZ;
    localparam int DEV_CLK_HZ = 7_372_800;
    localparam int DEV_CLK_DIV = 48;
    localparam int TICKS_PER_BIT = 16;
    localparam int TICK_HZ = DEV_CLK_HZ / DEV_CLK_DIV;
    localparam int BAUD_RATE = TICK_HZ / TICKS_PER_BIT;
    // A tick period rounds down to whole system cycles.
    localparam int TICK_CYCLES = SYS_CLK_HZ / TICK_HZ;
    localparam int DIV_W = 11;
    localparam logic [DIV_W-1:0] TICK_LAST = DIV_W'(TICK_CYCLES - 1);
    localparam logic [DIV_W-1:0] DIV_RESET = 11'h000;
    localparam logic [3:0] TICK_FINAL = 4'(TICKS_PER_BIT - 1);
    localparam logic [3:0] START_MID = 4'(TICKS_PER_BIT / 2 - 1);
    localparam int DATA_BITS = 8;
    localparam logic [2:0] LAST_BIT = 3'(DATA_BITS - 1);

    // -------------------------------------------------------------------
    // Start-up delays
    // -------------------------------------------------------------------
    localparam int CYCLES_PER_US = SYS_CLK_HZ / 1_000_000;
    localparam int PWRUP_DELAY_US = 72;
    localparam int PWRUP_CYCLES = PWRUP_DELAY_US * CYCLES_PER_US;
    localparam int OSC_STARTUP_US = 139;
    localparam int OSC_STARTUP_CYCLES = OSC_STARTUP_US * CYCLES_PER_US;
    localparam int DEVRST_NS = 100;
    localparam int DEVRST_CYCLES =
        (DEVRST_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
    localparam int SEQ_CNT_W = 20;

    // -------------------------------------------------------------------
    // Line levels and reset values
    // -------------------------------------------------------------------
    localparam logic LINE_IDLE = 1'h1;
    localparam logic LINE_START = 1'h0;
    localparam logic STATUS_INACTIVE_N = 1'h1;

    // -------------------------------------------------------------------
    // State types
    // -------------------------------------------------------------------
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
    typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_t;
    typedef enum logic [2:0] {
        SEQ_PWRUP, SEQ_OSC, SEQ_HOLD, SEQ_DEVRST, SEQ_RUN
    } seq_state_t;

endpackage : irlink_pkg

// ===== core/two_entry_buffer.sv
// Two-word buffer with valid/ready on both sides.
// Assumes both sides run on i_sys_clk; ready on the fill side drops when full.
module two_entry_buffer #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // Fill side
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    // Drain side
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);

    typedef struct packed {
        logic [1:0][WIDTH-1:0] mem;
        logic wr;
        logic rd;
        logic [1:0] cnt;
    } buf_state_t;

    buf_state_t st;
    buf_state_t next_st;
    logic push;
    logic pop;

    assign o_in_ready = (st.cnt != 2'h2);
    assign o_out_valid = (st.cnt != 2'h0);
    assign o_out_data = st.mem[st.rd];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wr] = i_in_data;
            next_st.wr = ~st.wr;
        end
        if (pop) begin
            next_st.rd = ~st.rd;
        end
        case ({push, pop})
            2'b10: next_st.cnt = st.cnt + 2'h1;
            2'b01: next_st.cnt = st.cnt - 2'h1;
            default: next_st.cnt = st.cnt;
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    buffer_bound_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        st.cnt != 2'h3) else $error("buffer count out of range");

endmodule : two_entry_buffer

// ===== core/startup_sequencer.sv
// Power-up delays and release from the active-low device reset.
// Assumes i_reset_n is synchronous to i_sys_clk.
module startup_sequencer #(
    parameter int PWRUP_CYCLES = irlink_pkg::PWRUP_CYCLES,
    parameter int OSC_CYCLES = irlink_pkg::OSC_STARTUP_CYCLES
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // Device reset pin and result
    input wire logic i_reset_n,
    output logic o_operational
);

    typedef struct packed {
        irlink_pkg::seq_state_t state;
        logic [irlink_pkg::SEQ_CNT_W-1:0] cnt;
    } seq_t;

    localparam logic [irlink_pkg::SEQ_CNT_W-1:0] PWRUP_LAST =
        irlink_pkg::SEQ_CNT_W'(PWRUP_CYCLES - 1);
    localparam logic [irlink_pkg::SEQ_CNT_W-1:0] OSC_LAST =
        irlink_pkg::SEQ_CNT_W'(OSC_CYCLES - 1);
    localparam logic [irlink_pkg::SEQ_CNT_W-1:0] DEVRST_LAST =
        irlink_pkg::SEQ_CNT_W'(irlink_pkg::DEVRST_CYCLES - 1);

    seq_t st;
    seq_t next_st;

    assign o_operational = (st.state == irlink_pkg::SEQ_RUN);

    always_comb begin
        next_st = st;
        next_st.cnt = st.cnt + 1'b1;
        case (st.state)
            irlink_pkg::SEQ_PWRUP: begin
                if (st.cnt == PWRUP_LAST) begin
                    next_st.state = irlink_pkg::SEQ_OSC;
                    next_st.cnt = '0;
                end
            end
            irlink_pkg::SEQ_OSC: begin
                if (st.cnt == OSC_LAST) begin
                    next_st.state = irlink_pkg::SEQ_HOLD;
                    next_st.cnt = '0;
                end
            end
            irlink_pkg::SEQ_HOLD: begin
                next_st.cnt = '0;
                if (i_reset_n) begin
                    next_st.state = irlink_pkg::SEQ_DEVRST;
                end
            end
            irlink_pkg::SEQ_DEVRST: begin
                if (!i_reset_n) begin
                    next_st.state = irlink_pkg::SEQ_HOLD;
                end else if (st.cnt == DEVRST_LAST) begin
                    next_st.state = irlink_pkg::SEQ_RUN;
                end
            end
            irlink_pkg::SEQ_RUN: begin
                next_st.cnt = '0;
                if (!i_reset_n) begin
                    next_st.state = irlink_pkg::SEQ_HOLD;
                end
            end
            default: begin
                next_st.state = irlink_pkg::SEQ_HOLD;
                next_st.cnt = '0;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            st <= '{state: irlink_pkg::SEQ_PWRUP, cnt: '0};
        end else begin
            st <= next_st;
        end
    end

endmodule : startup_sequencer

// ===== core/host_uart_port.sv
// Host-side serial port of the infrared link controller.
// Assumes all pins are synchronous to i_sys_clk and the far side of the
// stream ports is on-chip logic of the link protocol.
//
// Summary of operation
// - Request-to-send and clear-to-send stay local, never sent to the remote.
// - Carrier-detect level goes to the remote; high no carrier, low carrier.
// - Serial data and carrier, ring, terminal-ready levels pass to the remote.
// - Device stays in reset while the active-low reset input is low.
// - After reset rises an internal sequence runs before normal operation.
// - Power-up delay then oscillator delay; no traffic before both end.
// - Every serial bit period but the received stop bit holds exactly sixteen bit ticks.
// - Start bit and eight data bits are timed by bit ticks.
// - Stop bit is tick-timed when sending, not when receiving.
// - Serial rate fixed at 9600 baud from a 7.3728 MHz device clock.
// - Half-duplex: never sending to and receiving from the host together.
// - Data-set-ready low with a valid link, high without one.
// - Clear-to-send high means stop sending, low means host may send.
// - Terminal-ready goes to the remote as its data-set-ready; low ready.
// - Ring-indicator goes to the remote; high no ring, low ring.
module host_uart_port #(
    parameter int PWRUP_CYCLES = irlink_pkg::PWRUP_CYCLES,
    parameter int OSC_CYCLES = irlink_pkg::OSC_STARTUP_CYCLES,
    parameter int TICK_CYCLES = irlink_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_reset_n,
    // Host serial pins
    input wire logic i_host_tx,
    output logic o_host_rx,
    input wire logic i_rts_n,
    output logic o_cts_n,
    output logic o_dsr_n,
    input wire logic i_dtr_n,
    input wire logic i_cd_n,
    input wire logic i_ri_n,
    // Words from the host toward the link
    output logic o_up_valid,
    input wire logic i_up_ready,
    output logic [7:0] o_up_data,
    // Words from the link toward the host
    input wire logic i_down_valid,
    output logic o_down_ready,
    input wire logic [7:0] i_down_data,
    // Link status
    input wire logic i_link_up,
    output logic o_remote_cd_n,
    output logic o_remote_ri_n,
    output logic o_remote_dsr_n,
    output logic o_operational,
    output logic o_overrun
);

    // -------------------------------------------------------------------
    // State
    // -------------------------------------------------------------------
    typedef struct packed {
        logic [irlink_pkg::DIV_W-1:0] div;
        logic line_q;
        irlink_pkg::rx_state_t rx_state;
        logic [3:0] rx_tick;
        logic [2:0] rx_bit;
        logic [7:0] rx_shift;
        irlink_pkg::tx_state_t tx_state;
        logic [3:0] tx_tick;
        logic [2:0] tx_bit;
        logic [7:0] tx_shift;
        logic tx_line;
        logic dsr_n;
        logic cd_n;
        logic ri_n;
        logic dtr_n;
        logic overrun;
    } port_state_t;

    // Only a bench shortens the tick; the default keeps the fixed rate.
    localparam logic [irlink_pkg::DIV_W-1:0] TICK_LAST =
        irlink_pkg::DIV_W'(TICK_CYCLES - 1);

    port_state_t st;
    port_state_t next_st;
    logic tick;
    logic rx_push;
    logic buf_in_ready;
    logic run;

    startup_sequencer #(
        .PWRUP_CYCLES(PWRUP_CYCLES),
        .OSC_CYCLES(OSC_CYCLES)
    ) u_seq (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_reset_n(i_reset_n),
        .o_operational(run)
    );

    // The stop bit of a host word is not waited out in ticks, so a word is
    // handed on as soon as the line is seen high again.
    two_entry_buffer #(
        .WIDTH(8)
    ) u_up_buf (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_in_valid(rx_push),
        .o_in_ready(buf_in_ready),
        .i_in_data(st.rx_shift),
        .o_out_valid(o_up_valid),
        .i_out_ready(i_up_ready),
        .o_out_data(o_up_data)
    );

    // -------------------------------------------------------------------
    // Outputs
    // -------------------------------------------------------------------
    assign tick = (st.div == TICK_LAST);
    assign rx_push = (st.rx_state == irlink_pkg::RX_STOP) && st.line_q;
    // Transmission starts on a tick so the start bit gets all sixteen ticks.
    // A host start bit seen at the same tick wins, so both never start.
    assign o_down_ready = run && tick && !i_rts_n
        && (st.tx_state == irlink_pkg::TX_IDLE)
        && (st.rx_state == irlink_pkg::RX_IDLE)
        && (st.line_q == irlink_pkg::LINE_IDLE);
    // Held high while sending to the host so the line stays half-duplex.
    assign o_cts_n = !(run && buf_in_ready
        && (st.tx_state == irlink_pkg::TX_IDLE));
    assign o_host_rx = st.tx_line;
    assign o_dsr_n = st.dsr_n;
    assign o_remote_cd_n = st.cd_n;
    assign o_remote_ri_n = st.ri_n;
    assign o_remote_dsr_n = st.dtr_n;
    assign o_operational = run;
    assign o_overrun = st.overrun;

    // -------------------------------------------------------------------
    // Next state
    // -------------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.div = tick ? irlink_pkg::DIV_RESET : st.div + 1'b1;
        next_st.line_q = i_host_tx;
        next_st.overrun = rx_push && !buf_in_ready;
        // Modem lines toward the remote and the host's DSR; inactive until running.
        next_st.dsr_n = run ? !i_link_up : irlink_pkg::STATUS_INACTIVE_N;
        next_st.cd_n = run ? i_cd_n : irlink_pkg::STATUS_INACTIVE_N;
        next_st.ri_n = run ? i_ri_n : irlink_pkg::STATUS_INACTIVE_N;
        next_st.dtr_n = run ? i_dtr_n : irlink_pkg::STATUS_INACTIVE_N;

        // Receive from the host.
        case (st.rx_state)
            irlink_pkg::RX_IDLE: begin
                next_st.rx_tick = '0;
                if (run && tick && st.line_q == irlink_pkg::LINE_START
                    && st.tx_state == irlink_pkg::TX_IDLE) begin
                    next_st.rx_state = irlink_pkg::RX_START;
                end
            end
            irlink_pkg::RX_START: begin
                if (tick) begin
                    next_st.rx_tick = st.rx_tick + 1'b1;
                    if (st.rx_tick == irlink_pkg::START_MID) begin
                        next_st.rx_tick = '0;
                        next_st.rx_bit = '0;
                        next_st.rx_state =
                            (st.line_q == irlink_pkg::LINE_START) ?
                            irlink_pkg::RX_DATA : irlink_pkg::RX_IDLE;
                    end
                end
            end
            irlink_pkg::RX_DATA: begin
                if (tick) begin
                    next_st.rx_tick = st.rx_tick + 1'b1;
                    if (st.rx_tick == irlink_pkg::TICK_FINAL) begin
                        next_st.rx_shift = {st.line_q, st.rx_shift[7:1]};
                        next_st.rx_bit = st.rx_bit + 1'b1;
                        if (st.rx_bit == irlink_pkg::LAST_BIT) begin
                            next_st.rx_state = irlink_pkg::RX_STOP;
                        end
                    end
                end
            end
            irlink_pkg::RX_STOP: begin
                if (st.line_q) begin
                    next_st.rx_state = irlink_pkg::RX_IDLE;
                end
            end
            default: next_st.rx_state = irlink_pkg::RX_IDLE;
        endcase

        // Transmit to the host.
        case (st.tx_state)
            irlink_pkg::TX_IDLE: begin
                next_st.tx_tick = '0;
                next_st.tx_line = irlink_pkg::LINE_IDLE;
                if (i_down_valid && o_down_ready) begin
                    next_st.tx_shift = i_down_data;
                    next_st.tx_line = irlink_pkg::LINE_START;
                    next_st.tx_state = irlink_pkg::TX_START;
                end
            end
            irlink_pkg::TX_START: begin
                if (tick) begin
                    next_st.tx_tick = st.tx_tick + 1'b1;
                    if (st.tx_tick == irlink_pkg::TICK_FINAL) begin
                        next_st.tx_line = st.tx_shift[0];
                        next_st.tx_bit = '0;
                        next_st.tx_state = irlink_pkg::TX_DATA;
                    end
                end
            end
            irlink_pkg::TX_DATA: begin
                if (tick) begin
                    next_st.tx_tick = st.tx_tick + 1'b1;
                    if (st.tx_tick == irlink_pkg::TICK_FINAL) begin
                        next_st.tx_bit = st.tx_bit + 1'b1;
                        next_st.tx_shift = {1'b0, st.tx_shift[7:1]};
                        next_st.tx_line = st.tx_shift[1];
                        if (st.tx_bit == irlink_pkg::LAST_BIT) begin
                            next_st.tx_line = irlink_pkg::LINE_IDLE;
                            next_st.tx_state = irlink_pkg::TX_STOP;
                        end
                    end
                end
            end
            irlink_pkg::TX_STOP: begin
                if (tick) begin
                    next_st.tx_tick = st.tx_tick + 1'b1;
                    if (st.tx_tick == irlink_pkg::TICK_FINAL) begin
                        next_st.tx_state = irlink_pkg::TX_IDLE;
                    end
                end
            end
            default: next_st.tx_state = irlink_pkg::TX_IDLE;
        endcase

        // A device reset drops any character in flight.
        if (!run) begin
            next_st.rx_state = irlink_pkg::RX_IDLE;
            next_st.tx_state = irlink_pkg::TX_IDLE;
            next_st.tx_line = irlink_pkg::LINE_IDLE;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            st <= '{
                div: irlink_pkg::DIV_RESET,
                line_q: irlink_pkg::LINE_IDLE,
                rx_state: irlink_pkg::RX_IDLE,
                tx_state: irlink_pkg::TX_IDLE,
                tx_line: irlink_pkg::LINE_IDLE,
                dsr_n: irlink_pkg::STATUS_INACTIVE_N,
                cd_n: irlink_pkg::STATUS_INACTIVE_N,
                ri_n: irlink_pkg::STATUS_INACTIVE_N,
                dtr_n: irlink_pkg::STATUS_INACTIVE_N,
                default: '0
            };
        end else begin
            st <= next_st;
        end
    end

    // -------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_rst);

    logic [irlink_pkg::DIV_W-1:0] gap;
    logic seen_tick;
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            gap <= '0;
            seen_tick <= 1'b0;
        end else begin
            gap <= tick ? '0 : gap + 1'b1;
            seen_tick <= seen_tick | tick;
        end
    end

    tick_spacing_a: assert property (
        tick && seen_tick |-> gap == TICK_LAST)
        else $error("bit tick spacing wrong");
    cd_relay_a: assert property (run ##1 run |->
        o_remote_cd_n == $past(i_cd_n)) else $error("carrier not relayed");
    ri_relay_a: assert property (run ##1 run |->
        o_remote_ri_n == $past(i_ri_n)) else $error("ring not relayed");
    dtr_relay_a: assert property (run ##1 run |->
        o_remote_dsr_n == $past(i_dtr_n)) else $error("ready not relayed");
    dsr_link_a: assert property (run ##1 run |->
        o_dsr_n == !$past(i_link_up)) else $error("link status wrong");
    half_duplex_a: assert property (
        !(st.tx_state != irlink_pkg::TX_IDLE
          && st.rx_state != irlink_pkg::RX_IDLE))
        else $error("both directions busy");
    cts_block_a: assert property (
        st.tx_state != irlink_pkg::TX_IDLE |-> o_cts_n)
        else $error("clear to send while sending");
    rts_gate_a: assert property (
        i_down_valid && o_down_ready |-> !i_rts_n && run)
        else $error("sent to host while not ready");
    reset_hold_a: assert property (
        !i_reset_n |=> !o_operational ##1 !o_operational)
        else $error("running during reset");
    start_bit_a: assert property (
        i_down_valid && o_down_ready |=> !o_host_rx [*8])
        else $error("start bit missing");
    stop_level_a: assert property (
        st.tx_state == irlink_pkg::TX_STOP |-> o_host_rx)
        else $error("stop bit not high");

    word_in_c: cover property (rx_push && buf_in_ready);
    word_out_c: cover property (i_down_valid && o_down_ready);
    overrun_c: cover property (o_overrun);
    buffer_full_c: cover property (!buf_in_ready && o_cts_n);

endmodule : host_uart_port

// ===== tb/host_uart_model.sv
// Behavioural host controller UART with its request-to-send line for the bench.
// Assumes the bench calls its tasks just after a rising clock edge.
module host_uart_model #(
    parameter int BIT = irlink_pkg::TICKS_PER_BIT * irlink_pkg::TICK_CYCLES
) (
    // Clock
    input wire logic i_sys_clk,
    // Serial lines seen from the host
    input wire logic i_rx,
    output logic o_tx,
    output logic o_rts_n
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        o_tx = 1'b1;
        o_rts_n = 1'b1;
    end

    task automatic set_rts_n(input logic lvl);
        o_rts_n <= lvl;
    endtask : set_rts_n

    task automatic send_byte(input logic [7:0] data);
        logic [9:0] frame;
        frame = {1'b1, data, 1'b0};
        for (int b = 0; b < 10; b++) begin
            o_tx <= frame[b];
            repeat (BIT) @(posedge i_sys_clk);
        end
    endtask : send_byte

    // Samples mid-bit, so a drifting bit period corrupts the word.
    task automatic recv_byte(output logic [7:0] data, output logic ok);
        int n;
        n = 0;
        data = 8'h00;
        while (i_rx !== 1'b0 && n < 4 * BIT) begin
            @(posedge i_sys_clk);
            #1;
            n++;
        end
        ok = (n < 4 * BIT);
        repeat (BIT / 2) @(posedge i_sys_clk);
        #1;
        ok = ok && (i_rx === 1'b0);
        for (int b = 0; b < 8; b++) begin
            repeat (BIT) @(posedge i_sys_clk);
            #1;
            data[b] = i_rx;
        end
        repeat (BIT) @(posedge i_sys_clk);
        #1;
        ok = ok && (i_rx === 1'b1);
    endtask : recv_byte
endmodule : host_uart_model

// ===== tb/tb_host_uart_port.sv
// Self-checking bench for the host serial port of the infrared link.
// Assumes short start-up delays and a shortened bit tick, so that a
// character takes 1280 cycles and the whole run stays short.
module tb_host_uart_port;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TICK_CYC = 8;
    localparam int BIT = irlink_pkg::TICKS_PER_BIT * TICK_CYC;
    logic i_sys_clk, i_rst, i_reset_n, host_tx, host_rx, rts_n, cts_n;
    logic dsr_n, dtr_n, cd_n, ri_n, up_valid, up_ready, down_valid;
    logic down_ready, link_up, rcd, rri, rdsr, oper, ok, ovr;
    logic [7:0] up_data, down_data, got;
    int n_errors, samples_checked, n, n_ovr;

    host_uart_port #(.PWRUP_CYCLES(20), .OSC_CYCLES(20),
        .TICK_CYCLES(TICK_CYC)) u_host_uart_port (
        .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_reset_n(i_reset_n),
        .i_host_tx(host_tx), .o_host_rx(host_rx), .i_rts_n(rts_n),
        .o_cts_n(cts_n), .o_dsr_n(dsr_n), .i_dtr_n(dtr_n), .i_cd_n(cd_n),
        .i_ri_n(ri_n), .o_up_valid(up_valid), .i_up_ready(up_ready),
        .o_up_data(up_data), .i_down_valid(down_valid),
        .o_down_ready(down_ready), .i_down_data(down_data),
        .i_link_up(link_up), .o_remote_cd_n(rcd), .o_remote_ri_n(rri),
        .o_remote_dsr_n(rdsr), .o_operational(oper), .o_overrun(ovr));

    host_uart_model #(.BIT(BIT)) u_host_uart_model (
        .i_sys_clk(i_sys_clk), .i_rx(host_rx), .o_tx(host_tx),
        .o_rts_n(rts_n));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic final_report();
        $display("Mismatches %0d, checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report

    task automatic wait_high(input bit pick_valid, input int lim);
        int k;
        k = 0;
        while ((pick_valid ? up_valid : oper) !== 1'b1) begin
            if (k == lim) begin
                n_errors++;
                $display("[FAIL] t=%0t wait ran out", $time);
                final_report();
            end
            k++;
            @(posedge i_sys_clk);
            #1;
        end
    endtask : wait_high

    initial begin
        i_sys_clk = 1'b0;
        forever #2.5 i_sys_clk = ~i_sys_clk;
    end

    // The overrun flag stands one cycle; count it where it is settled.
    always @(negedge i_sys_clk) begin
        if (ovr === 1'b1) begin
            n_ovr++;
        end
    end

    initial begin
        {i_rst, i_reset_n, dtr_n, cd_n, ri_n} = 5'h1f;
        {up_ready, down_valid, link_up} = 3'h0;
        down_data = 8'h00;
        n_errors = 0;
        samples_checked = 0;
        n_ovr = 0;
        repeat (20) @(posedge i_sys_clk);
        #1;
        check({host_rx, cts_n, dsr_n, rcd, oper}, 32'h1e);
        @(posedge i_sys_clk);
        i_rst <= 1'b0;
        repeat (30) @(posedge i_sys_clk);
        #1;
        check(oper, 0);
        wait_high(0, 200);
        @(posedge i_sys_clk);
        {dtr_n, cd_n, ri_n, link_up} <= 4'h1;
        repeat (3) @(posedge i_sys_clk);
        #1;
        check({rcd, rri, rdsr, dsr_n}, 0);
        @(posedge i_sys_clk);
        {cd_n, link_up} <= 2'h2;
        repeat (3) @(posedge i_sys_clk);
        #1;
        check({rcd, rri, dsr_n}, 32'h5);
        @(posedge i_sys_clk);
        i_reset_n <= 1'b0;
        repeat (3) @(posedge i_sys_clk);
        #1;
        check(oper, 0);
        @(posedge i_sys_clk);
        i_reset_n <= 1'b1;
        repeat (5) @(posedge i_sys_clk);
        #1;
        check(oper, 0);
        wait_high(0, 100);
        check(cts_n, 0);
        @(posedge i_sys_clk);
        u_host_uart_model.send_byte(8'ha5);
        wait_high(1, 4 * BIT);
        check(up_data, 8'ha5);
        @(posedge i_sys_clk);
        up_ready <= 1'b1;
        @(posedge i_sys_clk);
        up_ready <= 1'b0;
        #1;
        check(up_valid, 0);
        // The host ignores the flow control here on purpose: the third word
        // finds the buffer full and is lost.
        u_host_uart_model.send_byte(8'h11);
        u_host_uart_model.send_byte(8'h22);
        #1;
        check(cts_n, 1);
        u_host_uart_model.send_byte(8'h33);
        @(posedge i_sys_clk);
        #1;
        check(n_ovr, 1);
        check(up_data, 8'h11);
        @(posedge i_sys_clk);
        up_ready <= 1'b1;
        @(posedge i_sys_clk);
        #1;
        check(up_data, 8'h22);
        @(posedge i_sys_clk);
        up_ready <= 1'b0;
        #1;
        check(up_valid, 0);
        check(cts_n, 0);
        // With the host not ready, a waiting word must never be taken.
        @(posedge i_sys_clk);
        down_valid <= 1'b1;
        down_data <= 8'h3c;
        n = 0;
        repeat (3000) begin
            @(posedge i_sys_clk);
            #1;
            n += int'(down_ready === 1'b1);
        end
        check(n, 0);
        @(posedge i_sys_clk);
        u_host_uart_model.set_rts_n(1'b0);
        fork
            u_host_uart_model.recv_byte(got, ok);
            begin
                n = 0;
                while (!(down_ready === 1'b1 && down_valid) && n < 3000) begin
                    @(posedge i_sys_clk);
                    #1;
                    n++;
                end
                check(n < 3000, 1);
                @(posedge i_sys_clk);
                down_valid <= 1'b0;
                #1;
                n = 0;
                while (host_rx === 1'b1 && n < 10) begin
                    @(posedge i_sys_clk);
                    #1;
                    n++;
                end
                n = 0;
                while (host_rx === 1'b0 && n < 4 * BIT) begin
                    @(posedge i_sys_clk);
                    #1;
                    n++;
                end
                check(n, 3 * BIT);
                check(cts_n, 1);
            end
        join
        check(got, 8'h3c);
        check(ok, 1);
        final_report();
    end
endmodule : tb_host_uart_port
